/* dtss_event_src.sv */
`timescale 1ns/10ps
`default_nettype none
module dtss_event_src (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [78:0] set_mask,
    input  wire logic [78:0] clr_mask,
    output logic [78:0]      event_flags
);
    // only the owning peripheral clears a flag, never the channel
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) event_flags <= '0;
        else event_flags <= (event_flags | set_mask) & ~clr_mask;
    end
endmodule : dtss_event_src
`default_nettype wire

/* dtss_map.svh */
`ifndef DTSS_MAP_SVH
`define DTSS_MAP_SVH

// byte addresses on the avalon slave, one word per register
`define DTSS_ADDR_CTRL_MAIN      8'h00
`define DTSS_ADDR_START_SEL      8'h04
`define DTSS_ADDR_ABORT_SEL      8'h08
`define DTSS_ADDR_STATUS         8'h0C

// channel_control_main field positions
`define DTSS_CTL_EN_BIT          7
`define DTSS_CTL_START_EN_BIT    6
`define DTSS_CTL_GO_BIT          5
`define DTSS_CTL_ABORT_EN_BIT    2
`define DTSS_CTL_XIP_BIT         0

// selector field
`define DTSS_SEL_MSB             6
`define DTSS_SEL_RESET           7'h00
`define DTSS_CODE_FIRST          7'h01
`define DTSS_CODE_LAST           7'h4E

// level-triggered code map, bit n set means code n is level sensitive
`define DTSS_LEVEL_MAP           80'h0000_0000_FF00_0010_3FF0_0080

`endif

/* dtss_pkg.sv */
package dtss_pkg;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
    } dtss_avl_req_t;

    typedef struct packed {
        logic        waitrequest;
        logic        readdatavalid;
        logic [31:0] readdata;
    } dtss_avl_rsp_t;

    typedef enum logic [2:0] {
        DTSS_IDLE  = 3'b001,
        DTSS_ACK   = 3'b010,
        DTSS_RUN   = 3'b100
    } dtss_phase_t;

    typedef struct packed {
        logic        enable;
        logic        start_request_enable;
        logic        abort_request_enable;
        logic        transfer_in_progress;
        logic [6:0]  start_source_code;
        logic [6:0]  abort_source_code;
        logic [78:0] src_prev;
        logic [31:0] rdata;
        logic        aborted;
        dtss_phase_t phase;
    } dtss_state_t;

endpackage : dtss_pkg

/* dtss_props.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dtss_map.svh"
module dtss_props (
    input wire logic                    clk,
    input wire logic                    sys_rst,
    input wire dtss_pkg::dtss_avl_req_t avl_req,
    input wire dtss_pkg::dtss_avl_rsp_t avl_rsp,
    input wire logic [78:0]             event_flags,
    input wire logic                    transfer_done,
    input wire logic                    start_pulse,
    input wire logic                    abort_pulse,
    input wire logic                    transfer_in_progress
);
    import dtss_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    bus_answer_a: assert property ((avl_req.read || avl_req.write) && avl_rsp.waitrequest
        |=> !avl_rsp.waitrequest) else $error("late answer");
    wait_single_a: assert property (!avl_rsp.waitrequest |=> avl_rsp.waitrequest)
        else $error("waitrequest low too long");
    abort_top_a: assert property (!avl_rsp.waitrequest && avl_req.read
        && avl_req.address == `DTSS_ADDR_ABORT_SEL |-> avl_rsp.readdata[31:7] == 0)
        else $error("abort selector top bits set");
    start_top_a: assert property (!avl_rsp.waitrequest && avl_req.read
        && avl_req.address == `DTSS_ADDR_START_SEL |-> avl_rsp.readdata[31:7] == 0)
        else $error("start selector top bits set");
    start_runs_a: assert property (start_pulse && !abort_pulse |=> transfer_in_progress)
        else $error("start without run");
    abort_stops_a: assert property (abort_pulse |=> !transfer_in_progress)
        else $error("abort did not stop");
    abort_busy_a: assert property (abort_pulse |-> transfer_in_progress)
        else $error("abort while idle");
    start_idle_a: assert property (start_pulse |-> !transfer_in_progress)
        else $error("start while busy");
endmodule : dtss_props
`default_nettype wire

/* dtss_trigger_select.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dtss_map.svh"
module dtss_trigger_select (
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire dtss_pkg::dtss_avl_req_t avl_req,
    output dtss_pkg::dtss_avl_rsp_t     avl_rsp,
    input  wire logic [78:0]            event_flags,
    input  wire logic                   transfer_done,
    output logic                        start_pulse,
    output logic                        abort_pulse,
    output logic                        transfer_in_progress
);
    import dtss_pkg::*;

    localparam logic [79:0] LEVEL_MAP = `DTSS_LEVEL_MAP;

    dtss_state_t r;
    dtss_state_t next_r;
    logic        start_hit;
    logic        abort_hit;
    logic        access;

    // reserved codes return no source so a stray code can never fire
    function automatic logic dtss_fire(input logic [6:0]  code,
                                       input logic [78:0] now,
                                       input logic [78:0] prev);
        logic hit;
        hit = 1'b0;
        if (code >= `DTSS_CODE_FIRST && code <= `DTSS_CODE_LAST) begin
            if (LEVEL_MAP[code]) begin
                hit = now[code];
            end else begin
                hit = now[code] & ~prev[code];
            end
        end
        return hit;
    endfunction : dtss_fire

    assign start_hit = dtss_fire(r.start_source_code, event_flags, r.src_prev);
    assign abort_hit = dtss_fire(r.abort_source_code, event_flags, r.src_prev);
    assign access    = avl_req.read | avl_req.write;

    always_comb begin
        next_r          = r;
        next_r.src_prev = event_flags; // flags are only sampled, never written back
        next_r.aborted  = 1'b0;
        start_pulse     = 1'b0;
        abort_pulse     = 1'b0;
        case (r.phase)
            DTSS_IDLE: begin
                if (access) begin
                    next_r.phase = DTSS_ACK;
                    next_r.rdata = 32'h0000_0000;
                    if (avl_req.write) begin
                        case (avl_req.address)
                            `DTSS_ADDR_CTRL_MAIN: begin
                                next_r.enable = avl_req.writedata[`DTSS_CTL_EN_BIT];
                                next_r.start_request_enable =
                                    avl_req.writedata[`DTSS_CTL_START_EN_BIT];
                                next_r.abort_request_enable =
                                    avl_req.writedata[`DTSS_CTL_ABORT_EN_BIT];
                                if (avl_req.writedata[`DTSS_CTL_GO_BIT] &&
                                    avl_req.writedata[`DTSS_CTL_EN_BIT]) begin
                                    next_r.transfer_in_progress = 1'b1;
                                end
                            end
                            `DTSS_ADDR_START_SEL: begin
                                next_r.start_source_code =
                                    avl_req.writedata[`DTSS_SEL_MSB:0];
                            end
                            `DTSS_ADDR_ABORT_SEL: begin
                                // bit 7 and above are dropped
                                next_r.abort_source_code =
                                    avl_req.writedata[`DTSS_SEL_MSB:0];
                            end
                            default: begin
                            end
                        endcase
                    end else begin
                        case (avl_req.address)
                            `DTSS_ADDR_CTRL_MAIN: begin
                                next_r.rdata[`DTSS_CTL_EN_BIT]       = r.enable;
                                next_r.rdata[`DTSS_CTL_START_EN_BIT] = r.start_request_enable;
                                next_r.rdata[`DTSS_CTL_GO_BIT]       = r.transfer_in_progress;
                                next_r.rdata[`DTSS_CTL_ABORT_EN_BIT] = r.abort_request_enable;
                                next_r.rdata[`DTSS_CTL_XIP_BIT]      = r.transfer_in_progress;
                            end
                            `DTSS_ADDR_START_SEL: begin
                                next_r.rdata[`DTSS_SEL_MSB:0] = r.start_source_code;
                            end
                            `DTSS_ADDR_ABORT_SEL: begin
                                next_r.rdata[`DTSS_SEL_MSB:0] = r.abort_source_code;
                            end
                            `DTSS_ADDR_STATUS: begin
                                next_r.rdata[1] = r.aborted;
                                next_r.rdata[0] = r.transfer_in_progress;
                            end
                            default: begin
                                next_r.rdata = 32'h0000_0000;
                            end
                        endcase
                    end
                end
            end
            DTSS_ACK: begin
                next_r.phase = DTSS_IDLE;
            end
            default: begin
                next_r.phase = DTSS_IDLE;
            end
        endcase
        // trigger path runs after the bus decode, so an abort, a done or r.enable low overrides a same-cycle software write of go
        if (r.enable) begin
            if (r.transfer_in_progress && r.abort_request_enable && abort_hit) begin
                next_r.transfer_in_progress = 1'b0;
                next_r.aborted              = 1'b1;
                abort_pulse                 = 1'b1;
            end else if (!r.transfer_in_progress && r.start_request_enable &&
                         start_hit) begin
                next_r.transfer_in_progress = 1'b1;
                start_pulse                 = 1'b1;
            end else if (r.transfer_in_progress && transfer_done) begin
                next_r.transfer_in_progress = 1'b0;
            end
        end else begin
            next_r.transfer_in_progress = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            r                      <= '0;
            r.phase                <= DTSS_IDLE;
            r.start_source_code    <= `DTSS_SEL_RESET;
            r.abort_source_code    <= `DTSS_SEL_RESET;
        end else begin
            r <= next_r;
        end
    end

    // waitrequest drops in the cycle after the request is seen
    always_comb begin
        avl_rsp.waitrequest   = ~(r.phase == DTSS_ACK);
        avl_rsp.readdatavalid = 1'b0;
        avl_rsp.readdata      = r.rdata;
    end

    assign transfer_in_progress = r.transfer_in_progress;

endmodule : dtss_trigger_select
`default_nettype wire

/* tb_dtss_trigger_select.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dtss_map.svh"
module tb_dtss_trigger_select;
    import dtss_pkg::*;
    logic          clk = 0, sys_rst = 1, transfer_done = 0;
    dtss_avl_req_t avl_req = '0;
    dtss_avl_rsp_t avl_rsp;
    logic [78:0]   set_mask = '0, clr_mask = '0, event_flags;
    logic          start_pulse, abort_pulse, transfer_in_progress;
    logic [31:0]   rd;
    int            num_errors = 0, total_checks = 0;
    always #4 clk = ~clk;
    dtss_event_src src (.clk(clk), .sys_rst(sys_rst), .set_mask(set_mask),
        .clr_mask(clr_mask), .event_flags(event_flags));
    dtss_trigger_select dut (.clk(clk), .sys_rst(sys_rst), .avl_req(avl_req),
        .avl_rsp(avl_rsp), .event_flags(event_flags), .transfer_done(transfer_done),
        .start_pulse(start_pulse), .abort_pulse(abort_pulse),
        .transfer_in_progress(transfer_in_progress));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avl_req <= '{read: !wr, write: wr, address: a, writedata: d};
        // waitrequest and readdata are read at the rising edge itself, before the flops move
        do begin
            @(posedge clk);
            n++;
        end while (avl_rsp.waitrequest && n < 20);
        if (avl_rsp.waitrequest) begin
            num_errors++;
            complete_run();
        end
        rd = avl_rsp.readdata;
        avl_req <= '0;
    endtask : bus
    // flags settle one edge, pulse follows in that same cycle, run bit one edge later
    task automatic fire(input logic [78:0] s, c, input logic d, exp);
        @(posedge clk);
        set_mask <= s;
        clr_mask <= c;
        transfer_done <= d;
        @(posedge clk);
        set_mask <= '0;
        clr_mask <= '0;
        transfer_done <= 0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check({31'h0, transfer_in_progress}, {31'h0, exp});
    endtask : fire
    task automatic t_regs;
        bus(0, `DTSS_ADDR_ABORT_SEL, 0); check(rd, 32'h0);
        bus(1, `DTSS_ADDR_ABORT_SEL, 32'hFFFF_FFFF);
        bus(0, `DTSS_ADDR_ABORT_SEL, 0); check(rd, 32'h7F);
        bus(1, `DTSS_ADDR_START_SEL, 32'hFFFF_FFFF);
        bus(0, `DTSS_ADDR_START_SEL, 0); check(rd, 32'h7F);
        bus(0, 8'h10, 0); check(rd, 32'h0);
        $display("regs done");
    endtask : t_regs
    task automatic t_trig;
        bus(1, `DTSS_ADDR_CTRL_MAIN, 32'hC4);
        bus(1, `DTSS_ADDR_START_SEL, 32'h1);
        bus(1, `DTSS_ADDR_ABORT_SEL, 32'h14);
        fire(79'h2, 0, 0, 1);
        fire(79'h10_0000, 0, 0, 0);
        check({31'h0, event_flags[1]}, 32'h1);
        fire(0, 0, 1, 0);
        fire(0, 79'h10_0002, 0, 0);
        bus(1, `DTSS_ADDR_START_SEL, 32'h7);
        fire(79'h80, 0, 0, 1);
        fire(0, 0, 1, 1);
        bus(1, `DTSS_ADDR_CTRL_MAIN, 32'h0);
        bus(1, `DTSS_ADDR_CTRL_MAIN, 32'hC4);
        bus(1, `DTSS_ADDR_START_SEL, 32'h4F);
        fire('1, 0, 0, 0);
        $display("triggers done");
    endtask : t_trig
    task automatic t_reset;
        @(posedge clk);
        sys_rst <= 1;
        repeat (2) @(posedge clk);
        sys_rst <= 0;
        bus(0, `DTSS_ADDR_START_SEL, 0); check(rd, 32'h0);
        $display("reset done");
    endtask : t_reset
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 0;
        t_regs();
        t_trig();
        t_reset();
        complete_run();
    end
endmodule : tb_dtss_trigger_select
bind dtss_trigger_select dtss_props chk (.clk(clk), .sys_rst(sys_rst), .avl_req(avl_req),
    .avl_rsp(avl_rsp), .event_flags(event_flags), .transfer_done(transfer_done),
    .start_pulse(start_pulse), .abort_pulse(abort_pulse),
    .transfer_in_progress(transfer_in_progress));
`default_nettype wire
